// ### hdl/config_checksum_crc32.sv
// Operation
// - A read-only 32-bit register holds the CRC over the protected configuration set.
// - The set is both irq masks, the mode, gain, config and capture registers plus 4x16 and 6x8 reserved bits.
// - Reserved registers always enter the CRC with their fixed default values; the code takes them from RES16_VALUE and RES8_VALUE, which can be overridden.
// - Registers enter the LFSR one at a time LSB first, internal reserved first, first irq mask last.
// - After any reset the CRC is computed over defaults; the register resets to 0x33666787.
// - All 32 LFSR state bits start at one.
// - The generator uses the CRC-32 polynomial of Ethernet.
// - Feedback is input XOR top bit, shifted with taps, 256 steps, final state stored.
// - With default reserved contents the state after step 48 equals 0x3A7ABC72.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crc_cfg.svh"
module config_checksum_crc32
   import crc_pkg::*;
#(
   parameter int          ADDR_W      = 18,
   parameter logic [63:0] RES16_VALUE = `RST_RES16,
   parameter logic [47:0] RES8_VALUE  = `RST_RES8
)
(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr
);
   // The decode needs a full 16-bit index plus the byte offset
   if (ADDR_W < 18)
      $error("ADDR_W must be at least 18");

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   function automatic logic [31:0] ext16(input logic [15:0] v);
      ext16 = {16'h0000, v};
   endfunction

   function automatic logic [31:0] ext8(input logic [7:0] v);
      ext8 = {24'h00_0000, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Protected registers, then the checksum register and its dirty flag
   logic [31:0] irq_line0_enable_mask_r;
   logic [31:0] irq_line1_enable_mask_r;
   logic [15:0] computation_mode_reg_r;
   logic [15:0] gain_reg_r;
   logic [15:0] config_reg_r;
   logic [7:0]  measurement_mode_reg_r;
   logic [7:0]  accumulation_mode_reg_r;
   logic [7:0]  line_cycle_mode_reg_r;
   logic [7:0]  fast_capture_setup_reg_r;
   logic [31:0] config_crc_value_r;
   logic        dirty_r;

   crc_link_if lnk ();

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire setup_w  = psel && !penable;
   wire access_w = psel && penable && pready;
   wire wr_w     = access_w && pwrite;

   wire hit_m0   = hit(paddr, `IDX_IRQ0_EN);
   wire hit_m1   = hit(paddr, `IDX_IRQ1_EN);
   wire hit_cm   = hit(paddr, `IDX_COMPUTATION_MODE);
   wire hit_gn   = hit(paddr, `IDX_GAIN);
   wire hit_cf   = hit(paddr, `IDX_CONFIG);
   wire hit_mm   = hit(paddr, `IDX_MEASUREMENT_MODE);
   wire hit_am   = hit(paddr, `IDX_ACCUMULATION_MODE);
   wire hit_lc   = hit(paddr, `IDX_LINE_CYCLE_MODE);
   wire hit_hs   = hit(paddr, `IDX_CAPCFG);
   wire hit_crc  = hit(paddr, `IDX_CRC);
   wire hit_st   = hit(paddr, `IDX_CRC_STAT);
   wire hit_prot = hit_m0 | hit_m1 | hit_cm | hit_gn | hit_cf | hit_mm | hit_am
                 | hit_lc | hit_hs;
   // Read-only registers refuse writes with an error
   wire bad_w    = !(hit_prot | ((hit_crc | hit_st) && !pwrite));

   // Write strobes, one per protected register
   wire we_m0     = wr_w && hit_m0;
   wire we_m1     = wr_w && hit_m1;
   wire we_cm     = wr_w && hit_cm;
   wire we_gn     = wr_w && hit_gn;
   wire we_cf     = wr_w && hit_cf;
   wire we_mm     = wr_w && hit_mm;
   wire we_am     = wr_w && hit_am;
   wire we_lc     = wr_w && hit_lc;
   wire we_hs     = wr_w && hit_hs;
   wire prot_wr_w = wr_w && hit_prot;

   logic [31:0] rd_mux;
   always_comb
   begin
      if (hit_m0)
         rd_mux = irq_line0_enable_mask_r;
      else if (hit_m1)
         rd_mux = irq_line1_enable_mask_r;
      else if (hit_cm)
         rd_mux = ext16(computation_mode_reg_r);
      else if (hit_gn)
         rd_mux = ext16(gain_reg_r);
      else if (hit_cf)
         rd_mux = ext16(config_reg_r);
      else if (hit_mm)
         rd_mux = ext8(measurement_mode_reg_r);
      else if (hit_am)
         rd_mux = ext8(accumulation_mode_reg_r);
      else if (hit_lc)
         rd_mux = ext8(line_cycle_mode_reg_r);
      else if (hit_hs)
         rd_mux = ext8(fast_capture_setup_reg_r);
      else if (hit_crc)
         rd_mux = config_crc_value_r;
      else if (hit_st)
         rd_mux = {30'h0000_0000, dirty_r, lnk.busy};
      else
         rd_mux = 32'h0000_0000;
   end

   // Answer in the cycle after setup; the outputs stand for that one cycle
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup_w;
         pslverr <= setup_w && bad_w;
         prdata  <= (setup_w && !pwrite && !bad_w) ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, one short process per register width
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         irq_line0_enable_mask_r <= `RST_IRQ0_EN;
         irq_line1_enable_mask_r <= `RST_IRQ1_EN;
      end
      else
      begin
         if (we_m0)
            irq_line0_enable_mask_r <= pwdata;
         if (we_m1)
            irq_line1_enable_mask_r <= pwdata;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         computation_mode_reg_r <= `RST_COMPUTATION_MODE;
         gain_reg_r             <= `RST_GAIN;
         config_reg_r           <= `RST_CONFIG;
      end
      else
      begin
         if (we_cm)
            computation_mode_reg_r <= pwdata[15:0];
         if (we_gn)
            gain_reg_r <= pwdata[15:0];
         if (we_cf)
            config_reg_r <= pwdata[15:0];
      end
   end

   // Upper write data bits of the narrow registers are dropped
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         measurement_mode_reg_r   <= `RST_MEASUREMENT_MODE;
         accumulation_mode_reg_r  <= `RST_ACCUMULATION_MODE;
         line_cycle_mode_reg_r    <= `RST_LINE_CYCLE_MODE;
         fast_capture_setup_reg_r <= `RST_CAPCFG;
      end
      else
      begin
         if (we_mm)
            measurement_mode_reg_r <= pwdata[7:0];
         if (we_am)
            accumulation_mode_reg_r <= pwdata[7:0];
         if (we_lc)
            line_cycle_mode_reg_r <= pwdata[7:0];
         if (we_hs)
            fast_capture_setup_reg_r <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checksum control
   // Vector a255..a0: first irq mask on top, 8-bit reserved at the bottom
   assign lnk.data = {irq_line0_enable_mask_r, irq_line1_enable_mask_r,
                      computation_mode_reg_r, gain_reg_r, config_reg_r,
                      measurement_mode_reg_r, accumulation_mode_reg_r,
                      line_cycle_mode_reg_r, fast_capture_setup_reg_r,
                      RES16_VALUE, RES8_VALUE};
   // The engine latches the vector at start, so a later write needs a rerun
   assign lnk.start = dirty_r && !lnk.busy;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         dirty_r            <= 1'b1;
         config_crc_value_r <= `RST_CRC;
      end
      else
      begin
         // A write in the start cycle keeps the flag set
         dirty_r <= (dirty_r && !lnk.start) || prot_wr_w;
         if (lnk.done)
            config_crc_value_r <= lnk.result;
      end
   end

   crc32_serial u_engine
   (
      .ref_clk (ref_clk),
      .srst    (srst),
      .lnk     (lnk.eng)
   );
endmodule
`default_nettype wire

// ### hdl/crc32_serial.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_cfg.svh"
module crc32_serial
   import crc_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic srst,
   crc_link_if.eng   lnk
);
   crc_state_t              state_r;
   logic [255:0]            shift_r;
   logic [31:0]             lfsr_r;
   logic [`CRC_CNT_W-1:0]   cnt_r;
   logic [31:0]             lfsr_nxt;

   assign lfsr_nxt   = lfsr_step(lfsr_r, shift_r[0], `CRC_POLY);
   assign lnk.busy   = (state_r == ST_RUN);
   assign lnk.result = lfsr_r;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state_r  <= ST_IDLE;
         shift_r  <= '0;
         lfsr_r   <= `CRC_INIT;
         cnt_r    <= '0;
         lnk.done <= 1'b0;
      end
      else
      begin
         lnk.done <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               if (lnk.start)
               begin
                  shift_r <= lnk.data;
                  lfsr_r  <= `CRC_INIT;
                  cnt_r   <= '0;
                  state_r <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               // Bit a0 enters first, LSB of the vector
               shift_r <= {1'b0, shift_r[255:1]};
               lfsr_r  <= lfsr_nxt;
               cnt_r   <= cnt_r + 1'b1;
               if (cnt_r == `CRC_LAST)
               begin
                  state_r  <= ST_IDLE;
                  lnk.done <= 1'b1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### hdl/crc_cfg.svh
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_IRQ0_EN            16'he50a
`define IDX_IRQ1_EN            16'he50b
`define IDX_COMPUTATION_MODE   16'he60e
`define IDX_GAIN               16'he60f
`define IDX_CONFIG             16'he618
`define IDX_MEASUREMENT_MODE   16'he700
`define IDX_ACCUMULATION_MODE  16'he701
`define IDX_LINE_CYCLE_MODE    16'he702
`define IDX_CAPCFG             16'he706
`define IDX_CRC                16'he51f
`define IDX_CRC_STAT           16'he7fe

// Reset values of the protected registers, the reserved bits and the checksum register
`define RST_IRQ0_EN            32'h0000_0000
`define RST_IRQ1_EN            32'h0000_0000
`define RST_COMPUTATION_MODE   16'h0000
`define RST_GAIN               16'h0000
`define RST_CONFIG             16'h0000
`define RST_MEASUREMENT_MODE   8'h00
`define RST_ACCUMULATION_MODE  8'h00
`define RST_LINE_CYCLE_MODE    8'h00
`define RST_CAPCFG             8'h00
`define RST_RES16              64'h0000_0000_0000_0000
`define RST_RES8               48'h0000_0000_0000
`define RST_CRC                32'h3366_6787

// Generator
`define CRC_POLY               32'h04c1_1db7
`define CRC_INIT               32'hffff_ffff
`define CRC_BITS               256
`define CRC_CNT_W              9
`define CRC_LAST               9'h0ff

`endif

// ### hdl/crc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crc_link_if;
   logic         start;
   logic [255:0] data;
   logic         busy;
   logic         done;
   logic [31:0]  result;

   modport ctrl (output start, output data, input busy, input done, input result);
   modport eng  (input start, input data, output busy, output done, output result);
endinterface
`default_nettype wire

// ### hdl/crc_pkg.sv
`default_nettype none
package crc_pkg;

   typedef enum logic {ST_IDLE, ST_RUN} crc_state_t;

   // One step of the LFSR: feedback is input XOR top bit, taps XORed into shifted state
   function automatic logic [31:0] lfsr_step(input logic [31:0] st, input logic din,
                                             input logic [31:0] poly);
      logic fb;
      fb = din ^ st[31];
      lfsr_step = {st[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000);
   endfunction

endpackage
`default_nettype wire

// ### test/crc_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_cfg.svh"
module crc_port_checker
#(
   parameter int ADDR_W = 18
)
(
   input wire logic              ref_clk,
   input wire logic              srst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr
);
   localparam logic [17:0] CRC_A = {`IDX_CRC, 2'b00};
   localparam logic [17:0] MSK_A = {`IDX_IRQ0_EN, 2'b00};
   logic [8:0] cnt_r;
   wire logic  setup_w;
   assign setup_w = psel && !penable;
   // Cycles since reset, saturating
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         cnt_r <= 9'h000;
      else if (cnt_r != 9'h1ff)
         cnt_r <= cnt_r + 9'h001;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   chk_ready_after_setup:
      assert property (setup_w |=> pready ##1 !pready) else $error("no single ready");
   chk_err_with_ready:
      assert property (pslverr |-> pready) else $error("error without ready");
   chk_rdata_quiet:
      assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
   chk_crc_ro:
      assert property (setup_w && pwrite && paddr == CRC_A |=> pslverr)
         else $error("checksum write accepted");
   chk_crc_read_ok:
      assert property (setup_w && !pwrite && paddr == CRC_A |=> pready && !pslverr)
         else $error("checksum read refused");
   chk_unmapped_err:
      assert property (setup_w && paddr == '0 |=> pslverr) else $error("unmapped accepted");
   chk_mask_write_ok:
      assert property (setup_w && pwrite && paddr == MSK_A |=> !pslverr)
         else $error("mask write refused");
   chk_reset_crc:
      assert property (pready && !pwrite && paddr == CRC_A && cnt_r < 9'h0c8
         |-> prdata == 32'h3366_6787) else $error("bad checksum after reset");
endmodule
bind config_checksum_crc32 crc_port_checker #(.ADDR_W(ADDR_W)) i_crc_port_checker
   (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "crc_cfg.svh"
module tb_top import crc_pkg::*;;
   logic        ref_clk = 1'b0;
   logic        srst    = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [17:0] paddr   = 18'h00000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] q;
   logic        e;
   int          n_errors = 0;
   int          samples_checked = 0;
   logic [31:0] rv [9];
   logic [15:0] ridx [9] = '{`IDX_IRQ0_EN, `IDX_IRQ1_EN, `IDX_COMPUTATION_MODE, `IDX_GAIN,
                             `IDX_CONFIG, `IDX_MEASUREMENT_MODE, `IDX_ACCUMULATION_MODE,
                             `IDX_LINE_CYCLE_MODE, `IDX_CAPCFG};
   logic [31:0] rmsk [9] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0000_ffff, 32'h0000_ffff,
                             32'h0000_ffff, 32'h0000_00ff, 32'h0000_00ff, 32'h0000_00ff,
                             32'h0000_00ff};

   always #2 ref_clk = ~ref_clk;

   config_checksum_crc32 i_config_checksum_crc32 (.ref_clk(ref_clk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] crc_exp();
      logic [255:0] v;
      logic [31:0]  b;
      logic         fb;
      v = {rv[0], rv[1], rv[2][15:0], rv[3][15:0], rv[4][15:0], rv[5][7:0], rv[6][7:0],
           rv[7][7:0], rv[8][7:0], `RST_RES16, `RST_RES8};
      b = 32'hffff_ffff;
      for (int j = 0; j < 256; j++)
      begin
         fb = v[j] ^ b[31];
         b = {b[30:0], 1'b0} ^ ({32{fb}} & `CRC_POLY);
      end
      return b;
   endfunction

   task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      do
      begin
         xfer(1'b0, `IDX_CRC_STAT, 32'h0);
         k++;
      end
      while (q[1:0] !== 2'b00 && k < 300);
      chk({30'h0, q[1:0]}, 32'h0);
   endtask

   task automatic do_reset();
      srst <= 1'b1;
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      foreach (rv[i]) rv[i] = 32'h0;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset();
      xfer(1'b0, `IDX_CRC, 32'h0);
      chk(q, `RST_CRC);
      wait_idle();
      xfer(1'b0, `IDX_CRC, 32'h0);
      chk(q, crc_exp());
      $display("test reset_default done");
      // Back-to-back writes while the engine runs
      for (int i = 0; i < 9; i++)
      begin
         xfer(1'b1, ridx[i], 32'h8421_fe5a ^ {4{i[7:0]}});
         chk({31'h0, e}, 32'h0);
         rv[i] = (32'h8421_fe5a ^ {4{i[7:0]}}) & rmsk[i];
      end
      wait_idle();
      xfer(1'b0, `IDX_CRC, 32'h0);
      chk(q, crc_exp());
      for (int i = 0; i < 9; i++)
      begin
         xfer(1'b0, ridx[i], 32'h0);
         chk(q, rv[i]);
      end
      $display("test protected_set done");
      xfer(1'b1, `IDX_CRC, 32'h0);
      chk({31'h0, e}, 32'h1);
      xfer(1'b0, 16'h0000, 32'h0);
      chk({31'h0, e}, 32'h1);
      xfer(1'b0, `IDX_CRC, 32'h0);
      chk(q, crc_exp());
      xfer(1'b0, `IDX_CRC, 32'h0);
      chk(q, crc_exp());
      $display("test read_only done");
      xfer(1'b1, `IDX_IRQ1_EN, 32'h0000_0001);
      xfer(1'b0, `IDX_CRC_STAT, 32'h0);
      chk({30'h0, q[1:0]}, 32'h1);
      do_reset();
      xfer(1'b0, `IDX_CRC, 32'h0);
      chk(q, `RST_CRC);
      xfer(1'b0, `IDX_IRQ1_EN, 32'h0);
      chk(q, `RST_IRQ1_EN);
      wait_idle();
      xfer(1'b0, `IDX_CRC, 32'h0);
      chk(q, crc_exp());
      $display("test mid_run_reset done");
      test_done();
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      test_done();
   end
endmodule
`default_nettype wire
